//--- pviu_defines.svh
`ifndef PVIU_DEFINES_SVH
`define PVIU_DEFINES_SVH

// Source and vector counts
`define PVIU_NUM_SRC     29
`define PVIU_NUM_VEC     10

// Vector addresses, lowest first
`define PVIU_VEC_ADDR_0  17'h00003
`define PVIU_VEC_ADDR_1  17'h0000b
`define PVIU_VEC_ADDR_2  17'h00013
`define PVIU_VEC_ADDR_3  17'h0001b
`define PVIU_VEC_ADDR_4  17'h00023
`define PVIU_VEC_ADDR_5  17'h0002b
`define PVIU_VEC_ADDR_6  17'h00033
`define PVIU_VEC_ADDR_7  17'h0003b
`define PVIU_VEC_ADDR_8  17'h00043
`define PVIU_VEC_ADDR_9  17'h0004b

// Source bit positions
`define PVIU_SRC_EXT_A    0
`define PVIU_SRC_EXT_B    1
`define PVIU_SRC_EXT_C    2
`define PVIU_SRC_T0L      3
`define PVIU_SRC_EXT_E    4
`define PVIU_SRC_EXT_D    5
`define PVIU_SRC_EXT_F    6
`define PVIU_SRC_BASE0    7
`define PVIU_SRC_BASE1    8
`define PVIU_SRC_T0H      9
`define PVIU_SRC_EXT_G    10
`define PVIU_SRC_T1L      11
`define PVIU_SRC_T1H      12
`define PVIU_SRC_EXT_H    13
`define PVIU_SRC_SS0      14
`define PVIU_SRC_SP1_RX   15
`define PVIU_SRC_SP2_RX   16
`define PVIU_SRC_ASS      17
`define PVIU_SRC_SS2      18
`define PVIU_SRC_SP1_TX   19
`define PVIU_SRC_SP2_TX   20
`define PVIU_SRC_ADC      21
`define PVIU_SRC_T6       22
`define PVIU_SRC_T7       23
`define PVIU_SRC_PG45     24
`define PVIU_SRC_PORT0    25
`define PVIU_SRC_T4       26
`define PVIU_SRC_T5       27
`define PVIU_SRC_PG01     28

// Vector to source map: bit n set when source n feeds the vector
`define PVIU_MAP_0 29'h0000001
`define PVIU_MAP_1 29'h0000002
`define PVIU_MAP_2 29'h000001c
`define PVIU_MAP_3 29'h00001e0
`define PVIU_MAP_4 29'h0000600
`define PVIU_MAP_5 29'h0003800
`define PVIU_MAP_6 29'h001c000
`define PVIU_MAP_7 29'h01e0000
`define PVIU_MAP_8 29'h1e00000
`define PVIU_MAP_9 29'h1e000000

// Stop-mode wake sources: ext A,B,C,E,F and port 0
`define PVIU_WAKE_STOP 29'h2000057
// Extra crystal-keeping stop wake: both base timer events
`define PVIU_WAKE_XTAL 29'h0000180

`endif

//--- pviu_pkg.sv
package pviu_pkg;

    // Priority level, ordered so a larger code is a stronger level
    typedef enum logic [1:0] {
        PVIU_LVL_NONE    = 2'h0,
        PVIU_LVL_LOW     = 2'h1,
        PVIU_LVL_HIGH    = 2'h2,
        PVIU_LVL_HIGHEST = 2'h3
    } pviu_level_type;

    // Standby modes of the core
    typedef enum logic [1:0] {
        PVIU_RUN       = 2'h0,
        PVIU_PAUSE     = 2'h1,
        PVIU_STOP      = 2'h2,
        PVIU_XTAL_STOP = 2'h3
    } pviu_mode_type;

    // Request offered to the core
    typedef struct packed {
        logic           valid;
        logic [3:0]     index;
        logic [16:0]    addr;
        pviu_level_type level;
    } pviu_req_type;

    // Oscillator run enables
    typedef struct packed {
        logic ceramic;
        logic rc;
        logic crystal;
    } pviu_osc_type;

endpackage : pviu_pkg

//--- pviu_arbiter.sv
`timescale 1ns/1ps
`include "pviu_defines.svh"

module pviu_arbiter
    import pviu_pkg::*;
(
    input  wire logic [9:0]    vec_pend_in,
    input  wire logic [19:0]   vec_level_in,
    input  pviu_level_type     cur_level_in,
    output logic               win_valid_out,
    output logic [3:0]         win_index_out,
    output pviu_level_type     win_level_out
);

    // Scan from the top vector down so the smallest address wins ties
    always_comb begin
        win_valid_out = 1'b0;
        win_index_out = 4'h0;
        win_level_out = PVIU_LVL_NONE;
        for (int i = 9; i >= 0; i--) begin
            if (vec_pend_in[i] &&
                vec_level_in[2*i +: 2] >= 2'(win_level_out) &&
                vec_level_in[2*i +: 2] != 2'h0) begin
                win_valid_out = 1'b1;
                win_index_out = 4'(i);
                win_level_out = pviu_level_type'(vec_level_in[2*i +: 2]);
            end
        end
        // Only strictly higher than in service
        if (win_level_out <= cur_level_in) begin
            win_valid_out = 1'b0;
        end
    end

endmodule : pviu_arbiter

//--- pviu_top.sv
`timescale 1ns/1ps
`include "pviu_defines.svh"

// How it works
// R1: Three nesting levels, highest above high above low.
// R2: Requests at or below the level in service are held off.
// R3: Simultaneous requests: highest level wins.
// R4: Same level: smallest vector address wins.
// R5: 29 sources are folded onto 10 vectors.
// R6: Pins A and B use the first two vectors, highest or low only.
// R7: Third vector: pin C, timer zero low, pin E; high or low.
// R8: Fourth vector: pins D, F and both base timer events.
// R9: Fifth: timer zero high, pin G; sixth: timer one halves, pin H.
// R10: Seventh and eighth vectors collect serial receive and transmit events.
// R11: Ninth: converter, timers 6,7, pulses 4,5; tenth: port 0, timers 4,5, pulses 0,1.
// R12: Pause ends on reset or any interrupt.
// R13: Stop ends on reset pin low, pins A,B,C,E,F, or port 0.
// R14: Crystal-keeping stop also ends on a base timer event.
// R15: Stop halts all oscillators; crystal stop keeps crystal and base timer.
// R16: Source flags stick until accepted or cleared; vector ORs enabled flags.
module pviu_top
    import pviu_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                reset_n_in,
    input  wire logic [28:0]         src_event_in,
    input  wire logic [28:0]         src_enable_in,
    input  wire logic [28:0]         src_clear_in,
    input  wire logic [19:0]         vec_level_in,
    input  wire logic                ack_in,
    input  wire logic                ret_in,
    input  wire logic                reset_pin_in,
    input  pviu_mode_type            mode_req_in,
    output pviu_req_type             req_out,
    output pviu_level_type           cur_level_out,
    output pviu_mode_type            mode_out,
    output pviu_osc_type             osc_out,
    output logic                     base_timer_run_out,
    output logic [28:0]              src_flag_out
);

    logic [28:0]    evt_meta_reg;
    logic [28:0]    evt_sync_reg;
    logic [28:0]    evt_prev_reg;
    logic           rst_meta_reg;
    logic           rst_sync_reg;
    logic [28:0]    flag_reg;
    logic [28:0]    flag_next;
    logic [28:0]    vec_map [10];
    logic [16:0]    vec_addr [10];
    logic [9:0]     vec_pend;
    logic [19:0]    lvl_fixed;
    logic [28:0]    evt_rise;
    logic [28:0]    ack_mask;
    logic           win_valid;
    logic [3:0]     win_index;
    pviu_level_type win_level;
    pviu_level_type stack_reg [3];
    logic [1:0]     depth_reg;
    pviu_req_type   req_reg;
    pviu_mode_type  mode_reg;
    logic           any_flag;
    logic           stop_wake;
    logic           xtal_wake;

    // R7 R8 R9 R10 R11 source group tables
    assign vec_map[0] = `PVIU_MAP_0;
    assign vec_map[1] = `PVIU_MAP_1;
    assign vec_map[2] = `PVIU_MAP_2;
    assign vec_map[3] = `PVIU_MAP_3;
    assign vec_map[4] = `PVIU_MAP_4;
    assign vec_map[5] = `PVIU_MAP_5;
    assign vec_map[6] = `PVIU_MAP_6;
    assign vec_map[7] = `PVIU_MAP_7;
    assign vec_map[8] = `PVIU_MAP_8;
    assign vec_map[9] = `PVIU_MAP_9;
    assign vec_addr[0] = `PVIU_VEC_ADDR_0;
    assign vec_addr[1] = `PVIU_VEC_ADDR_1;
    assign vec_addr[2] = `PVIU_VEC_ADDR_2;
    assign vec_addr[3] = `PVIU_VEC_ADDR_3;
    assign vec_addr[4] = `PVIU_VEC_ADDR_4;
    assign vec_addr[5] = `PVIU_VEC_ADDR_5;
    assign vec_addr[6] = `PVIU_VEC_ADDR_6;
    assign vec_addr[7] = `PVIU_VEC_ADDR_7;
    assign vec_addr[8] = `PVIU_VEC_ADDR_8;
    assign vec_addr[9] = `PVIU_VEC_ADDR_9;

    // Pin synchronisers, two stages each
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            evt_meta_reg <= 29'h0;
            evt_sync_reg <= 29'h0;
            evt_prev_reg <= 29'h0;
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
        end else begin
            evt_meta_reg <= src_event_in;
            evt_sync_reg <= evt_meta_reg;
            evt_prev_reg <= evt_sync_reg;
            rst_meta_reg <= reset_pin_in;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign evt_rise = evt_sync_reg & ~evt_prev_reg;

    // Level fixing per vector and pending OR
    genvar gv;
    generate
        for (gv = 0; gv < 10; gv++) begin : g_vec
            // R6 pins A,B: high folds to highest
            // R7 R8 R9 R10 R11 others: highest folds to high
            if (gv < 2) begin : g_xl
                assign lvl_fixed[2*gv +: 2] = (vec_level_in[2*gv +: 2] == 2'h2) ?
                                              2'h3 : vec_level_in[2*gv +: 2];
            end else begin : g_hl
                assign lvl_fixed[2*gv +: 2] = (vec_level_in[2*gv +: 2] == 2'h3) ?
                                              2'h2 : vec_level_in[2*gv +: 2];
            end
            // R5 shared vector OR; R16 enabled flags only
            assign vec_pend[gv] = |(flag_reg & src_enable_in & vec_map[gv]);
        end
    endgenerate

    // R1 R3 R4 R2 level compare and arbitration
    pviu_arbiter u_arb (
        .vec_pend_in   (vec_pend),
        .vec_level_in  (lvl_fixed),
        .cur_level_in  (depth_reg == 2'h0 ? PVIU_LVL_NONE : stack_reg[depth_reg - 2'h1]),
        .win_valid_out (win_valid),
        .win_index_out (win_index),
        .win_level_out (win_level)
    );

    // Clear mask for an accepted vector
    assign ack_mask = (ack_in && req_reg.valid) ? (vec_map[req_reg.index] & src_enable_in)
                                                : 29'h0;

    // R16 sticky flags, a new event wins over a clear
    always_comb begin
        flag_next = (flag_reg & ~(src_clear_in | ack_mask)) | evt_rise;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_reg <= 29'h0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Offered request, registered
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_reg <= '0;
        end else if (ack_in && req_reg.valid) begin
            req_reg <= '0;
        end else begin
            req_reg.valid <= win_valid && (mode_reg == PVIU_RUN || mode_reg == PVIU_PAUSE);
            req_reg.index <= win_index;
            req_reg.addr  <= vec_addr[win_index];
            req_reg.level <= win_level;
        end
    end

    // R2 service level stack: push on accept, pop on return
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            depth_reg <= 2'h0;
            for (int i = 0; i < 3; i++) begin
                stack_reg[i] <= PVIU_LVL_NONE;
            end
        end else if (ack_in && req_reg.valid && depth_reg != 2'h3) begin
            stack_reg[depth_reg] <= req_reg.level;
            depth_reg            <= depth_reg + 2'h1;
        end else if (ret_in && depth_reg != 2'h0) begin
            depth_reg <= depth_reg - 2'h1;
        end
    end

    // Wake conditions
    assign any_flag  = |vec_pend;
    // R13 stop wake sources
    assign stop_wake = !rst_sync_reg || |(flag_reg & `PVIU_WAKE_STOP);
    // R14 base timer adds to crystal stop
    assign xtal_wake = stop_wake || |(flag_reg & `PVIU_WAKE_XTAL);

    // Standby mode state
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_reg <= PVIU_RUN;
        end else begin
            unique case (mode_reg)
                PVIU_RUN: begin
                    mode_reg <= mode_req_in;
                end
                // R12 pause ends on any interrupt
                PVIU_PAUSE: begin
                    if (any_flag) begin
                        mode_reg <= PVIU_RUN;
                    end
                end
                PVIU_STOP: begin
                    if (stop_wake) begin
                        mode_reg <= PVIU_RUN;
                    end
                end
                PVIU_XTAL_STOP: begin
                    if (xtal_wake) begin
                        mode_reg <= PVIU_RUN;
                    end
                end
            endcase
        end
    end

    // R15 oscillator and base timer enables
    assign osc_out.ceramic    = (mode_reg != PVIU_STOP) && (mode_reg != PVIU_XTAL_STOP);
    assign osc_out.rc         = osc_out.ceramic;
    assign osc_out.crystal    = (mode_reg != PVIU_STOP);
    assign base_timer_run_out = (mode_reg != PVIU_STOP);

    assign req_out       = req_reg;
    assign cur_level_out = (depth_reg == 2'h0) ? PVIU_LVL_NONE : stack_reg[depth_reg - 2'h1];
    assign mode_out      = mode_reg;
    assign src_flag_out  = flag_reg;

endmodule : pviu_top

//--- pviu_core_model.sv
`timescale 1ns/1ps
module pviu_core_model
    import pviu_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  pviu_req_type    req_in,
    input  wire logic       take_in,
    input  wire logic [1:0] delay_in,
    input  wire logic       ret_cmd_in,
    output logic            ack_out,
    output logic            ret_out
);
    logic [1:0] wait_reg;
    // Accept a standing request after a think time
    always_ff @(negedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_reg <= 2'h0;
            ack_out  <= 1'b0;
        end else begin
            ack_out  <= req_in.valid && take_in && !ack_out && wait_reg == delay_in;
            wait_reg <= (req_in.valid && !ack_out) ? wait_reg + 2'h1 : 2'h0;
        end
    end
    // One return pulse per command
    always_ff @(negedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ret_out <= 1'b0;
        end else begin
            ret_out <= ret_cmd_in && !ret_out;
        end
    end
endmodule : pviu_core_model

//--- pviu_top_chk.sv
`timescale 1ns/1ps
module pviu_top_chk
    import pviu_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [28:0] src_event_in,
    input  wire logic        ack_in,
    input  wire logic        reset_pin_in,
    input  pviu_req_type     req_out,
    input  pviu_level_type   cur_level_out,
    input  pviu_mode_type    mode_out,
    input  pviu_osc_type     osc_out,
    input  wire logic        base_timer_run_out,
    input  wire logic [28:0] src_flag_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Request taken by the core
    sequence taken_s;
        req_out.valid && ack_in;
    endsequence
    // Edge on pin A
    sequence pin_a_s;
        $rose(src_event_in[0]);
    endsequence
    lvl_above_a: assert property (req_out.valid |-> req_out.level > cur_level_out)
        else $error("request not above");
    vec_addr_a: assert property (req_out.valid |-> req_out.index < 4'ha &&
        req_out.addr == {10'h0, req_out.index, 3'h3}) else $error("bad vector");
    pin_lvl_a: assert property (req_out.valid && req_out.index < 4'h2 |->
        req_out.level != PVIU_LVL_HIGH) else $error("pin level");
    ack_drop_a: assert property (taken_s |=> !req_out.valid)
        else $error("request kept");
    ack_push_a: assert property (taken_s |=> cur_level_out == $past(req_out.level))
        else $error("level not pushed");
    stop_osc_a: assert property (mode_out == PVIU_STOP |-> osc_out == 3'h0 &&
        !base_timer_run_out) else $error("stop oscillators");
    flag_set_a: assert property (pin_a_s |-> ##[1:4] src_flag_out[0])
        else $error("flag not set");
    pin_wake_a: assert property (mode_out == PVIU_STOP && !reset_pin_in |->
        ##[1:5] mode_out == PVIU_RUN) else $error("no pin wake");
endmodule : pviu_top_chk
bind pviu_top pviu_top_chk chk (.*);

//--- test_prioritized_vector_interrupt_unit.sv
`timescale 1ns/1ps
module test_prioritized_vector_interrupt_unit;
    import pviu_pkg::*;
    logic           clk_in = 1'b0;
    logic           reset_n_in = 1'b0;
    logic [28:0]    ev = 29'h0;
    logic [28:0]    en = 29'h1fffffff;
    logic [28:0]    clr = 29'h0;
    logic [19:0]    lvl = 20'h55555;
    logic           rpin = 1'b1;
    pviu_mode_type  mreq = PVIU_RUN;
    logic           take = 1'b0;
    logic [1:0]     dly = 2'h0;
    logic           rcmd = 1'b0;
    logic           ack;
    logic           ret;
    logic           bt;
    pviu_req_type   req;
    pviu_level_type cur;
    pviu_mode_type  mode;
    pviu_osc_type   osc;
    logic [28:0]    flag;
    int             errors = 0;
    int             num_checks = 0;
    int             n;
    int             wk[6] = '{0, 1, 2, 4, 6, 25};
    // Clock
    always #5 clk_in = ~clk_in;
    pviu_top uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .src_event_in(ev),
        .src_enable_in(en), .src_clear_in(clr), .vec_level_in(lvl), .ack_in(ack),
        .ret_in(ret), .reset_pin_in(rpin), .mode_req_in(mreq), .req_out(req),
        .cur_level_out(cur), .mode_out(mode), .osc_out(osc),
        .base_timer_run_out(bt), .src_flag_out(flag));
    pviu_core_model core (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req),
        .take_in(take), .delay_in(dly), .ret_cmd_in(rcmd), .ack_out(ack), .ret_out(ret));
    task summarize;
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task tk(input int c);
        repeat (c) @(negedge clk_in);
    endtask : tk
    task hang;
        errors++;
        summarize();
    endtask : hang
    task fire(input logic [28:0] m);
        ev <= m;
        tk(3);
        ev <= 29'h0;
        tk(1);
    endtask : fire
    task wait_lvl(input pviu_level_type l);
        for (n = 0; n < 40 && cur !== l; n++)
            tk(1);
        if (n == 40)
            hang();
    endtask : wait_lvl
    task wait_mode(input pviu_mode_type m);
        for (n = 0; n < 40 && mode !== m; n++)
            tk(1);
        if (n == 40)
            hang();
    endtask : wait_mode
    // Expect a request, let the core take it
    task grant(input logic [3:0] i, input pviu_level_type l);
        for (n = 0; n < 40 && req.valid !== 1'b1; n++)
            tk(1);
        if (n == 40)
            hang();
        chk({req.index, req.addr, req.level}, {i, 10'h0, i, 3'h3, l});
        take <= 1'b1;
        wait_lvl(l);
        take <= 1'b0;
    endtask : grant
    task ret1(input pviu_level_type l);
        rcmd <= 1'b1;
        tk(1);
        rcmd <= 1'b0;
        wait_lvl(l);
    endtask : ret1
    // Every source reaches its own vector
    task s_map;
        int v;
        for (int s = 0; s < 29; s++) begin
            v = (s > 0) + (s > 1) + (s > 4) + (s > 8) + (s > 10) + (s > 13) + (s > 16)
                + (s > 20) + (s > 24);
            fire(29'h1 << s);
            grant(v[3:0], PVIU_LVL_LOW);
            chk(flag, 29'h0);
            ret1(PVIU_LVL_NONE);
        end
    endtask : s_map
    // Ordering and nesting
    task s_prio;
        lvl <= 20'h555e9;
        dly <= 2'h3;
        fire(29'h25);
        grant(4'h2, PVIU_LVL_HIGH);
        tk(8);
        chk(req.valid, 1'b0);
        fire(29'h2);
        grant(4'h1, PVIU_LVL_HIGHEST);
        ret1(PVIU_LVL_HIGH);
        tk(4);
        chk(req.valid, 1'b0);
        ret1(PVIU_LVL_NONE);
        grant(4'h3, PVIU_LVL_HIGH);
        ret1(PVIU_LVL_NONE);
        grant(4'h0, PVIU_LVL_LOW);
        ret1(PVIU_LVL_NONE);
        lvl <= 20'h55555;
        dly <= 2'h0;
    endtask : s_prio
    // Disabled source keeps its flag quietly
    task s_mask;
        en <= 29'h1fefffff;
        fire(29'h100000);
        tk(4);
        chk({req.valid, flag}, 30'h100000);
        clr <= 29'h100000;
        tk(1);
        clr <= 29'h0;
        en <= 29'h1fffffff;
        tk(2);
        chk(flag, 29'h0);
    endtask : s_mask
    // Standby entry, clocks, wake-up
    task s_mode(input pviu_mode_type m, input logic [3:0] o, input logic [28:0] w);
        mreq <= m;
        tk(1);
        mreq <= PVIU_RUN;
        wait_mode(m);
        chk({osc, bt}, o);
        if (w == 29'h0) begin
            fire(29'h80);
            tk(4);
            chk(mode, PVIU_STOP);
            rpin <= 1'b0;
        end else begin
            fire(w);
        end
        wait_mode(PVIU_RUN);
        rpin <= 1'b1;
        take <= 1'b1;
        wait_lvl(PVIU_LVL_LOW);
        take <= 1'b0;
        ret1(PVIU_LVL_NONE);
    endtask : s_mode
    initial begin
        tk(4);
        reset_n_in <= 1'b1;
        tk(1);
        chk({req.valid, flag, mode, osc, cur}, 37'h1c);
        s_map();
        s_prio();
        s_mask();
        s_mode(PVIU_PAUSE, 4'hf, 29'h200000);
        s_mode(PVIU_XTAL_STOP, 4'h3, 29'h80);
        s_mode(PVIU_STOP, 4'h0, 29'h0);
        foreach (wk[k])
            s_mode(PVIU_STOP, 4'h0, 29'h1 << wk[k]);
        summarize();
    end
endmodule : test_prioritized_vector_interrupt_unit
